// ### sys_ctrl_pkg.sv
// constants and types for the system handler and protection control block
// What this block does
// - stack alignment field reads one; eight-byte alignment on exception entry
// - entry records alignment pad in stacked status bit 9; return restores it
// - unaligned trap field reads one; unaligned accesses raise hard fault
// - supervisor call priority in bits 31:30 of priority two, reset zero
// - tick timer priority in bits 31:30 of priority three, reset zero
// - pendable service priority in bits 23:22 of priority three, reset zero
// - supervisor call pending reads state; write one sets, zero clears
// - instruction region count reads zero
// - data region count reads eight, read only
// - separate maps bit reads zero
// - enable zero means default map for all aligned accesses; one enables protection
// - background map bit ignored while enable is clear
// - enabled, no background map: uncovered access faults
// - enabled with background map: default map for privileged accesses only
// - background acts as region minus one; real regions win
// - fault handler bit zero disables protection in fault and nmi handlers
package sys_ctrl_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [15:0] OFS_CORE_CONFIG = 16'hED14;
  localparam logic [15:0] OFS_PRIO_TWO = 16'hED1C;
  localparam logic [15:0] OFS_PRIO_THREE = 16'hED20;
  localparam logic [15:0] OFS_HANDLER_STATE = 16'hED24;
  localparam logic [15:0] OFS_PROT_TYPE = 16'hED90;
  localparam logic [15:0] OFS_PROT_CTRL = 16'hED94;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'hEDF0;
  localparam logic [15:0] OFS_IRQ_MASK = 16'hEDF4;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int STACK_ALIGN_BIT = 9;
  localparam int UNALIGNED_TRAP_BIT = 3;
  localparam int PRIO_HI_LSB = 30;
  localparam int PENDABLE_PRIO_LSB = 22;
  localparam int SVC_PENDING_BIT = 15;
  localparam int DATA_REGION_LSB = 8;
  localparam int INSTR_REGION_LSB = 16;
  localparam int SEPARATE_BIT = 0;
  localparam int PROT_ENABLE_BIT = 0;
  localparam int FAULT_PROT_BIT = 1;
  localparam int BACKGROUND_BIT = 2;
  localparam int STACKED_ALIGN_BIT = 9;
  // ----------------------------------------
  // reset and fixed values
  // ----------------------------------------
  localparam logic [1:0] PRIO_RESET = 2'h0;
  localparam logic [7:0] DATA_REGION_COUNT = 8'h08;
  localparam logic [7:0] INSTR_REGION_COUNT = 8'h00;
  localparam int NUM_REGIONS = 8;
  // interrupt status bits
  localparam int EV_FAULT = 0;
  localparam int EV_SVC_SET = 1;
  localparam int NUM_EVENTS = 2;

  typedef struct packed {
    logic enable;
    logic fault_handler_protection;
    logic background_map_enable;
  } prot_ctrl_s;

  typedef struct packed {
    logic [31:0] addr;
    logic privileged;
    logic unaligned;
    logic in_fault_handler;
  } access_s;

  typedef enum logic [1:0] {
    MAP_DEFAULT,
    MAP_REGION,
    MAP_BACKGROUND,
    MAP_FAULT
  } map_sel_e;
endpackage

// ### region_check.sv
// protection decision for one access
`timescale 1ns/1ps
module region_check #(
  parameter int REGIONS = 8
) (
  input wire sys_ctrl_pkg::prot_ctrl_s ctrl,
  input wire sys_ctrl_pkg::access_s acc,
  input wire logic [REGIONS-1:0] region_hit,
  output logic fault,
  output sys_ctrl_pkg::map_sel_e map_sel
);
  wire any_hit = |region_hit;
  wire prot_on = ctrl.enable &&
    !(acc.in_fault_handler && !ctrl.fault_handler_protection);
  wire bg_ok = ctrl.background_map_enable && acc.privileged;

  always_comb begin
    fault = 1'b0;
    map_sel = sys_ctrl_pkg::MAP_DEFAULT;
    if (acc.unaligned) begin
      fault = 1'b1;
      map_sel = sys_ctrl_pkg::MAP_FAULT;
    end else if (!prot_on) begin
      map_sel = sys_ctrl_pkg::MAP_DEFAULT;
    end else if (any_hit) begin
      map_sel = sys_ctrl_pkg::MAP_REGION;
    end else if (bg_ok) begin
      map_sel = sys_ctrl_pkg::MAP_BACKGROUND;
    end else begin
      fault = 1'b1;
      map_sel = sys_ctrl_pkg::MAP_FAULT;
    end
  end
endmodule

// ### sys_ctrl_regs.sv
// apb register block for system handlers and protection control
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module sys_ctrl_regs #(
  parameter int REGIONS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sys_ctrl_pkg::access_s acc,
  input wire logic [REGIONS-1:0] region_hit,
  input wire logic svc_taken,
  input wire logic svc_raise,
  input wire logic entry_pad,
  input wire logic exc_return,
  input wire logic stacked_align,
  output logic stacked_pad_bit,
  output logic restore_pad,
  output logic access_fault,
  output sys_ctrl_pkg::map_sel_e map_sel,
  output logic [1:0] svc_handler_priority,
  output logic [1:0] tick_timer_priority,
  output logic [1:0] pendable_service_priority,
  output logic supervisor_call_pending,
  output sys_ctrl_pkg::prot_ctrl_s prot_ctrl,
  output logic irq
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    return a[15:2] == o[15:2];
  endfunction

  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire sel_cfg = hit(paddr, sys_ctrl_pkg::OFS_CORE_CONFIG);
  wire sel_p2 = hit(paddr, sys_ctrl_pkg::OFS_PRIO_TWO);
  wire sel_p3 = hit(paddr, sys_ctrl_pkg::OFS_PRIO_THREE);
  wire sel_hs = hit(paddr, sys_ctrl_pkg::OFS_HANDLER_STATE);
  wire sel_ty = hit(paddr, sys_ctrl_pkg::OFS_PROT_TYPE);
  wire sel_pc = hit(paddr, sys_ctrl_pkg::OFS_PROT_CTRL);
  wire sel_st = hit(paddr, sys_ctrl_pkg::OFS_IRQ_STATUS);
  wire sel_mk = hit(paddr, sys_ctrl_pkg::OFS_IRQ_MASK);
  wire mapped = sel_cfg | sel_p2 | sel_p3 | sel_hs | sel_ty | sel_pc |
    sel_st | sel_mk;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------
  // stored fields
  // ----------------------------------------
  logic [sys_ctrl_pkg::NUM_EVENTS-1:0] irq_status;
  logic [sys_ctrl_pkg::NUM_EVENTS-1:0] irq_mask;
  logic fault_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_handler_priority <= sys_ctrl_pkg::PRIO_RESET;
    end else if (wr && sel_p2) begin
      svc_handler_priority <=
        pwdata[sys_ctrl_pkg::PRIO_HI_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_timer_priority <= sys_ctrl_pkg::PRIO_RESET;
      pendable_service_priority <= sys_ctrl_pkg::PRIO_RESET;
    end else if (wr && sel_p3) begin
      tick_timer_priority <= pwdata[sys_ctrl_pkg::PRIO_HI_LSB +: 2];
      pendable_service_priority <=
        pwdata[sys_ctrl_pkg::PENDABLE_PRIO_LSB +: 2];
    end
  end

  // pending: hardware raise wins over a clear
  wire sw_svc_write = wr && sel_hs;
  wire sw_svc_val = pwdata[sys_ctrl_pkg::SVC_PENDING_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_call_pending <= 1'b0;
    end else if (svc_raise || (sw_svc_write && sw_svc_val)) begin
      supervisor_call_pending <= 1'b1;
    end else if (svc_taken || sw_svc_write) begin
      supervisor_call_pending <= 1'b0;
    end
  end

  // protection control, software owns the bit ordering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_ctrl <= '0;
    end else if (wr && sel_pc) begin
      prot_ctrl.enable <= pwdata[sys_ctrl_pkg::PROT_ENABLE_BIT];
      prot_ctrl.fault_handler_protection <=
        pwdata[sys_ctrl_pkg::FAULT_PROT_BIT];
      prot_ctrl.background_map_enable <=
        pwdata[sys_ctrl_pkg::BACKGROUND_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr && sel_mk) begin
      irq_mask <= pwdata[sys_ctrl_pkg::NUM_EVENTS-1:0];
    end
  end

  // ----------------------------------------
  // protection decision
  // ----------------------------------------
  logic fault_c;
  sys_ctrl_pkg::map_sel_e map_c;
  region_check #(.REGIONS(REGIONS)) u_check (
    .ctrl(prot_ctrl),
    .acc(acc),
    .region_hit(region_hit),
    .fault(fault_c),
    .map_sel(map_c)
  );

  // alignment pad recorded on entry, restored on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_fault <= 1'b0;
      map_sel <= sys_ctrl_pkg::MAP_DEFAULT;
      stacked_pad_bit <= 1'b0;
      restore_pad <= 1'b0;
    end else begin
      access_fault <= fault_c;
      map_sel <= map_c;
      stacked_pad_bit <= entry_pad;
      restore_pad <= exc_return && stacked_align;
    end
  end

  // ----------------------------------------
  // event status, cleared by read
  // ----------------------------------------
  wire [sys_ctrl_pkg::NUM_EVENTS-1:0] ev;
  assign ev[sys_ctrl_pkg::EV_FAULT] = fault_c && !fault_q;
  assign ev[sys_ctrl_pkg::EV_SVC_SET] = svc_raise;
  wire st_read = rd && sel_st;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_c;
    end
  end

  // new events win over the read clear
  // only bits the read returned are cleared, so an event that lands on
  // the setup edge, after the snapshot, is kept for the next read
  generate
    for (genvar i = 0; i < sys_ctrl_pkg::NUM_EVENTS; i++) begin : g_ev
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_status[i] <= 1'b0;
        end else if (ev[i]) begin
          irq_status[i] <= 1'b1;
        end else if (st_read && prdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (sel_cfg) begin
      next_rdata[sys_ctrl_pkg::STACK_ALIGN_BIT] = 1'b1;
      next_rdata[sys_ctrl_pkg::UNALIGNED_TRAP_BIT] = 1'b1;
    end
    if (sel_p2) begin
      next_rdata[sys_ctrl_pkg::PRIO_HI_LSB +: 2] = svc_handler_priority;
    end
    if (sel_p3) begin
      next_rdata[sys_ctrl_pkg::PRIO_HI_LSB +: 2] = tick_timer_priority;
      next_rdata[sys_ctrl_pkg::PENDABLE_PRIO_LSB +: 2] =
        pendable_service_priority;
    end
    if (sel_hs) begin
      next_rdata[sys_ctrl_pkg::SVC_PENDING_BIT] = supervisor_call_pending;
    end
    if (sel_ty) begin
      next_rdata[sys_ctrl_pkg::INSTR_REGION_LSB +: 8] =
        sys_ctrl_pkg::INSTR_REGION_COUNT;
      next_rdata[sys_ctrl_pkg::DATA_REGION_LSB +: 8] =
        sys_ctrl_pkg::DATA_REGION_COUNT;
      next_rdata[sys_ctrl_pkg::SEPARATE_BIT] = 1'b0;
    end
    if (sel_pc) begin
      next_rdata[sys_ctrl_pkg::PROT_ENABLE_BIT] = prot_ctrl.enable;
      next_rdata[sys_ctrl_pkg::FAULT_PROT_BIT] =
        prot_ctrl.fault_handler_protection;
      next_rdata[sys_ctrl_pkg::BACKGROUND_BIT] =
        prot_ctrl.background_map_enable;
    end
    if (sel_st) begin
      next_rdata[sys_ctrl_pkg::NUM_EVENTS-1:0] = irq_status;
    end
    if (sel_mk) begin
      next_rdata[sys_ctrl_pkg::NUM_EVENTS-1:0] = irq_mask;
    end
  end

  // read data registered at setup so it stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_p2_write;
    wr && sel_p2;
  endsequence

  svc_prio_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_p2_write |=> svc_handler_priority == $past(pwdata[31:30]))
    else $error("svc priority not written");

  pend_prio_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && sel_p3 |=> pendable_service_priority == $past(pwdata[23:22]))
    else $error("pendable priority not written");

  tick_prio_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && sel_p3 |=> tick_timer_priority == $past(pwdata[31:30]))
    else $error("tick priority not written");

  svc_raise_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    svc_raise |=> supervisor_call_pending)
    else $error("svc raise lost");

  svc_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sw_svc_write && !sw_svc_val && !svc_raise |=> !supervisor_call_pending)
    else $error("svc pending not cleared");

  cfg_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && sel_cfg |=> prdata == 32'h00000208)
    else $error("config read wrong");

  type_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && sel_ty |=> prdata == 32'h00000800)
    else $error("type read wrong");

  disabled_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !prot_ctrl.enable && !acc.unaligned |=> map_sel == sys_ctrl_pkg::MAP_DEFAULT)
    else $error("disabled map not default");

  uncovered_fault_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    prot_ctrl.enable && prot_ctrl.fault_handler_protection &&
    !prot_ctrl.background_map_enable && region_hit == '0 |=> access_fault)
    else $error("uncovered access did not fault");

  unpriv_bg_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    prot_ctrl.enable && prot_ctrl.fault_handler_protection &&
    !acc.privileged && region_hit == '0 |=> access_fault)
    else $error("unprivileged used background");

  region_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    prot_ctrl.enable && !acc.in_fault_handler && !acc.unaligned &&
    region_hit != '0 |=> map_sel == sys_ctrl_pkg::MAP_REGION)
    else $error("region lost to background");

  fault_bypass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc.in_fault_handler && !prot_ctrl.fault_handler_protection &&
    !acc.unaligned |=> !access_fault)
    else $error("fault handler not bypassed");

  unaligned_trap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc.unaligned |=> access_fault)
    else $error("unaligned access not trapped");

  pad_restore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exc_return && stacked_align |=> restore_pad)
    else $error("alignment not restored");

  stack_pad_rec_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    entry_pad |=> stacked_pad_bit)
    else $error("alignment pad not recorded");

  bg_ignored_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !prot_ctrl.enable && !acc.unaligned |=> !access_fault)
    else $error("disabled protection faulted");

  ctrl_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && sel_pc |=> prot_ctrl.enable == $past(pwdata[0]))
    else $error("protection enable not written");

  pend_write_one_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sw_svc_write && sw_svc_val |=> supervisor_call_pending)
    else $error("svc pending not set by write");

  hs_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && sel_hs |=>
    prdata[15] == $past(supervisor_call_pending))
    else $error("svc pending read wrong");

  unmapped_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && !mapped |=> $stable(prot_ctrl) && $stable(irq_mask))
    else $error("unmapped write changed state");

  svc_event_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    svc_raise |=> irq_status[sys_ctrl_pkg::EV_SVC_SET])
    else $error("svc event not recorded");

  status_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_read && prdata[sys_ctrl_pkg::EV_SVC_SET] && !svc_raise |=>
    !irq_status[sys_ctrl_pkg::EV_SVC_SET])
    else $error("status not cleared by read");
endmodule

// ### tb_sys_ctrl_regs.sv
// self-checking bench for the system handler and protection register block
`timescale 1ns/1ps
module tb_sys_ctrl_regs;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  sys_ctrl_pkg::access_s acc;
  logic [7:0] region_hit;
  logic svc_taken, svc_raise, entry_pad, exc_return, stacked_align;
  logic stacked_pad_bit, restore_pad, access_fault, irq;
  logic supervisor_call_pending;
  sys_ctrl_pkg::map_sel_e map_sel;
  logic [1:0] svc_handler_priority, tick_timer_priority;
  logic [1:0] pendable_service_priority;
  sys_ctrl_pkg::prot_ctrl_s prot_ctrl;
  int failures, checks;
  logic [31:0] rdata;
  logic rerr;
  logic [15:0] regs [6];
  logic [31:0] rst_val [6];
  logic [31:0] ones_val [6];

  sys_ctrl_regs #(.REGIONS(8)) u_sys_ctrl_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc(acc), .region_hit(region_hit),
    .svc_taken(svc_taken), .svc_raise(svc_raise), .entry_pad(entry_pad),
    .exc_return(exc_return), .stacked_align(stacked_align),
    .stacked_pad_bit(stacked_pad_bit), .restore_pad(restore_pad),
    .access_fault(access_fault), .map_sel(map_sel),
    .svc_handler_priority(svc_handler_priority),
    .tick_timer_priority(tick_timer_priority),
    .pendable_service_priority(pendable_service_priority),
    .supervisor_call_pending(supervisor_call_pending),
    .prot_ctrl(prot_ctrl), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task conclude;
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdata, rerr);
  endtask

  task rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rdata, rerr);
    check(rdata, exp);
    check({31'h0, rerr}, 32'h0000_0000);
  endtask

  // one access against a protection setting, decision seen a cycle later
  task prot(input logic [2:0] c, input logic p, input logic f,
            input logic u, input logic h, input logic ef,
            input logic [1:0] em);
    wr(sys_ctrl_pkg::OFS_PROT_CTRL, {29'h0, c});
    @(posedge pclk);
    acc <= {32'h2000_0000, p, u, f};
    region_hit <= h ? 8'h04 : 8'h00;
    @(posedge pclk);
    #1;
    check({31'h0, access_fault}, {31'h0, ef});
    check({30'h0, map_sel}, {30'h0, em});
    check({29'h0, prot_ctrl}, {29'h0, c[0], c[1], c[2]});
  endtask

  task raise_svc;
    @(posedge pclk);
    svc_raise <= 1'b1;
    @(posedge pclk);
    svc_raise <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, svc_taken, svc_raise} = 5'h00;
    {entry_pad, exc_return, stacked_align} = 3'h0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    acc = '0;
    region_hit = 8'h00;
    failures = 0;
    checks = 0;
    presetn = 1'b0;
    regs = '{sys_ctrl_pkg::OFS_CORE_CONFIG, sys_ctrl_pkg::OFS_PRIO_TWO,
             sys_ctrl_pkg::OFS_PRIO_THREE, sys_ctrl_pkg::OFS_HANDLER_STATE,
             sys_ctrl_pkg::OFS_PROT_TYPE, sys_ctrl_pkg::OFS_PROT_CTRL};
    rst_val = '{32'h0000_0208, 32'h0, 32'h0, 32'h0, 32'h0000_0800, 32'h0};
    ones_val = '{32'h0000_0208, 32'hC000_0000, 32'hC0C0_0000,
                 32'h0000_8000, 32'h0000_0800, 32'h0000_0007};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(regs[i], rst_val[i]);
    // fixed fields and reserved bits ignore writes
    for (int i = 0; i < 6; i++)
      wr(regs[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++)
      rd(regs[i], ones_val[i]);
    apb(1'b0, 16'hED98, 32'h0, rdata, rerr);
    check({rdata[31:1], rerr}, 32'h0000_0001);
    wr(sys_ctrl_pkg::OFS_PRIO_TWO, 32'h4000_0000);
    rd(sys_ctrl_pkg::OFS_PRIO_TWO, 32'h4000_0000);
    check({30'h0, svc_handler_priority}, 32'h0000_0001);
    wr(sys_ctrl_pkg::OFS_PRIO_THREE, 32'h8040_0000);
    rd(sys_ctrl_pkg::OFS_PRIO_THREE, 32'h8040_0000);
    check({30'h0, tick_timer_priority}, 32'h0000_0002);
    check({30'h0, pendable_service_priority}, 32'h0000_0001);
    // pending set and clear paths
    wr(sys_ctrl_pkg::OFS_HANDLER_STATE, 32'h0000_0000);
    rd(sys_ctrl_pkg::OFS_HANDLER_STATE, 32'h0000_0000);
    raise_svc();
    check({31'h0, supervisor_call_pending}, 32'h0000_0001);
    @(posedge pclk);
    svc_taken <= 1'b1;
    @(posedge pclk);
    svc_taken <= 1'b0;
    rd(sys_ctrl_pkg::OFS_HANDLER_STATE, 32'h0000_0000);
    // protection decisions; fault bit set while enable is clear only for an unaligned access
    prot(3'h0, 0, 0, 0, 0, 0, sys_ctrl_pkg::MAP_DEFAULT);
    prot(3'h4, 0, 0, 0, 0, 0, sys_ctrl_pkg::MAP_DEFAULT);
    prot(3'h1, 1, 0, 0, 0, 1, sys_ctrl_pkg::MAP_FAULT);
    prot(3'h1, 0, 0, 0, 1, 0, sys_ctrl_pkg::MAP_REGION);
    prot(3'h5, 1, 0, 0, 0, 0, sys_ctrl_pkg::MAP_BACKGROUND);
    prot(3'h5, 0, 0, 0, 0, 1, sys_ctrl_pkg::MAP_FAULT);
    prot(3'h5, 1, 0, 0, 1, 0, sys_ctrl_pkg::MAP_REGION);
    prot(3'h1, 1, 1, 0, 0, 0, sys_ctrl_pkg::MAP_DEFAULT);
    prot(3'h3, 1, 1, 0, 0, 1, sys_ctrl_pkg::MAP_FAULT);
    prot(3'h0, 1, 0, 1, 0, 1, sys_ctrl_pkg::MAP_FAULT);
    // stack alignment record and restore
    @(posedge pclk);
    entry_pad <= 1'b1;
    @(posedge pclk);
    #1;
    check({31'h0, stacked_pad_bit}, 32'h0000_0001);
    @(posedge pclk);
    entry_pad <= 1'b0;
    exc_return <= 1'b1;
    stacked_align <= 1'b1;
    @(posedge pclk);
    exc_return <= 1'b0;
    #1;
    check({31'h0, restore_pad}, 32'h0000_0001);
    check({31'h0, stacked_pad_bit}, 32'h0000_0000);
    @(posedge pclk);
    #1;
    check({31'h0, restore_pad}, 32'h0000_0000);
    // interrupt: raise while masked, unmask, clear by read
    prot(3'h0, 0, 0, 0, 0, 0, sys_ctrl_pkg::MAP_DEFAULT);
    apb(1'b0, sys_ctrl_pkg::OFS_IRQ_STATUS, 32'h0, rdata, rerr);
    wr(sys_ctrl_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    prot(3'h1, 0, 0, 0, 0, 1, sys_ctrl_pkg::MAP_FAULT);
    raise_svc();
    check({31'h0, irq}, 32'h0000_0000);
    wr(sys_ctrl_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    #1;
    check({31'h0, irq}, 32'h0000_0001);
    rd(sys_ctrl_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    rd(sys_ctrl_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    rd(sys_ctrl_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    conclude();
  end
endmodule
